// file: mmrb_pkg.sv
// shared constants of the motion monitor register bank
package mmrb_pkg;

  // holding-register addresses (upper half of each 32-bit item)
  localparam logic [15:0] HR_IO_SNAPSHOT          = 16'h00d4;
  localparam logic [15:0] HR_TORQUE_RATIO         = 16'h00d6;
  localparam logic [15:0] HR_CUMULATIVE_LOAD      = 16'h00da;
  localparam logic [15:0] HR_TARGET_POSITION      = 16'h00de;
  localparam logic [15:0] HR_SUCCESSOR_DATA_NUMBER = 16'h00e0;
  localparam logic [15:0] HR_LOOP_START_NUMBER    = 16'h00e2;
  localparam logic [15:0] HR_LOOP_ITERATIONS      = 16'h00e4;
  localparam logic [15:0] HR_STEP_EVENT_CMD_POS   = 16'h00e6;
  localparam logic [15:0] HR_STEP_EVENT_FB_POS    = 16'h00e8;
  localparam logic [15:0] HR_LOW_EVENT_CMD_POS    = 16'h00ea;
  localparam logic [15:0] HR_LOW_EVENT_FB_POS     = 16'h00ec;
  localparam logic [15:0] HR_HIGH_EVENT_CMD_POS   = 16'h00ee;
  localparam logic [15:0] HR_HIGH_EVENT_FB_POS    = 16'h00f0;
  localparam logic [15:0] HR_HALT_EVENT_CMD_POS   = 16'h00f2;
  localparam logic [15:0] HR_HALT_EVENT_FB_POS    = 16'h00f4;
  localparam logic [15:0] HR_INFO_CODE            = 16'h00f6;
  localparam logic [15:0] HR_DRIVER_TEMP          = 16'h00f8;
  localparam logic [15:0] HR_MOTOR_TEMP           = 16'h00fa;
  localparam logic [15:0] HR_LIFETIME_REVS        = 16'h00fc;
  localparam logic [15:0] HR_RESETTABLE_REVS      = 16'h00fe;
  localparam logic [15:0] HR_EXEC_HISTORY_NEWEST  = 16'h0100;
  localparam logic [15:0] HR_EXEC_HISTORY_SECOND  = 16'h0102;

  // network command code of the item at HR_IO_SNAPSHOT; codes then step by one per register pair
  localparam logic [15:0] CMD_CODE_BASE = 16'h206a;

  // value shown when no data number applies
  localparam logic [31:0] NO_NUMBER = 32'hffffffff;

  // one revolution pulse per motor turn; one count is 0.1 kRev
  localparam int REVS_PER_UNIT = 100;
  localparam int HISTORY_DEPTH = 16;

  // event channel indices
  localparam int EV_STEP  = 0;
  localparam int EV_LOW   = 1;
  localparam int EV_HIGH  = 2;
  localparam int EV_HALT  = 3;
  localparam int EV_COUNT = 4;

endpackage : mmrb_pkg

// file: mmrb_monitor_bank.sv
// read-only motion monitor register bank with holding-register and command-code read ports
`timescale 1ns/1ps
`default_nettype none

// Operation
// R1: next-step event captures command and feedback positions.
// R2: low-level branch event captures command and feedback positions.
// R3: high-level branch event captures command and feedback positions.
// R4: halt by stop input captures command and feedback positions.
// R5: a repeated event overwrites the held positions.
// R6: cleared event latch reads zero until next capture.
// R7: successor number of running operation, kept after; minus one if unlinked or stop.
// R8: loop origin number while looping, else minus one.
// R9: loop iteration count while looping, else zero.
// R10: history of executed numbers; minus one when stopped; newest mirrors current.
// R11: destination-type operations show absolute destination as target.
// R12: continuous, jog, sensor or push homing show start position as target.
// R13: temperatures are signed, one count per 0.1 degree Celsius.
// R14: lifetime revolutions in 0.1 kRev, never clearable.
// R15: resettable revolutions in same unit, cleared by user request.
// R16: cumulative load adds load magnitude regardless of direction.
// R17: torque shown as ratio of maximum holding torque.
// R18: live snapshot of direct, extended, differential and virtual I/O.
// R19: presently active information code.
// R20: 32-bit items read as two 16-bit registers, upper half first.
module mmrb_monitor_bank #(
  parameter int HIST_DEPTH = mmrb_pkg::HISTORY_DEPTH,
  parameter int REV_UNIT   = mmrb_pkg::REVS_PER_UNIT
) (
  input  wire  logic        clk_sys,
  input  wire  logic        rst_b,
  // pins sampled asynchronously
  input  wire  logic [31:0] ioPins,
  // motion controller state, same clock
  input  wire  logic [31:0] cmdPosition,
  input  wire  logic [31:0] fbPosition,
  input  wire  logic [31:0] torqueRatio,
  input  wire  logic [31:0] loadSample,
  input  wire  logic        loadValid,
  input  wire  logic        running,
  input  wire  logic        opStart,
  input  wire  logic [31:0] opNumber,
  input  wire  logic        opUsesDestination,
  input  wire  logic [31:0] opDestination,
  input  wire  logic        linkEnabled,
  input  wire  logic        successorIsStop,
  input  wire  logic [31:0] successorNumber,
  input  wire  logic        loopActive,
  input  wire  logic [31:0] loopOrigin,
  input  wire  logic        loopPass,
  input  wire  logic [mmrb_pkg::EV_COUNT-1:0] eventPulse,
  input  wire  logic [mmrb_pkg::EV_COUNT-1:0] eventClear,
  input  wire  logic [31:0] infoCode,
  input  wire  logic [15:0] driverTemp,
  input  wire  logic [15:0] motorTemp,
  input  wire  logic        revPulse,
  input  wire  logic        tripClear,
  // holding-register read port
  input  wire  logic        hrRead,
  input  wire  logic [15:0] hrAddr,
  output logic        [15:0] hrData,
  output logic               hrValid,
  // network command-code read port
  input  wire  logic        ncRead,
  input  wire  logic [15:0] ncCode,
  output logic        [31:0] ncData,
  output logic               ncValid
);
  import mmrb_pkg::*;

  logic        rstMeta;
  logic        rstSync;
  logic [31:0] ioMeta;
  logic [31:0] ioSync;
  logic [31:0] target;
  logic [31:0] successor;
  logic [31:0] loopStart;
  logic [31:0] loopCount;
  logic        loopWas;
  logic [31:0] loadSum;
  logic [31:0] loadMag;
  logic [31:0] lifetimeRevs;
  logic [31:0] tripRevs;
  logic [15:0] revSub;
  logic        unitTick;
  logic [31:0] evCmd [EV_COUNT];
  logic [31:0] evFb  [EV_COUNT];
  logic [31:0] hist  [HIST_DEPTH];
  logic [15:0] pairLow;
  logic [15:0] pairAddr;
  logic        pairHeld;
  logic [15:0] ncAddr;
  logic [31:0] hrWord;
  logic [31:0] ncWord;
  logic [31:0] driverTempWide;
  logic [31:0] motorTempWide;

  // reset released through two flops
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // I/O pins cross into the clock domain before anything looks at them
  always_ff @(posedge clk_sys or negedge rstSync) begin
    if (!rstSync) begin
      ioMeta <= 32'h0;
      ioSync <= 32'h0;
    end else begin
      ioMeta <= ioPins;
      ioSync <= ioMeta;  // [R18]
    end
  end

  // target position chosen at operation start
  // the start position is the command position seen on the start edge
  always_ff @(posedge clk_sys or negedge rstSync) begin
    if (!rstSync) begin
      target <= 32'h0;
    end else if (opStart) begin
      if (opUsesDestination) begin
        target <= opDestination;  // [R11]
      end else begin
        target <= cmdPosition;  // [R12]
      end
    end
  end

  // successor is latched and kept after the operation completes
  always_ff @(posedge clk_sys or negedge rstSync) begin
    if (!rstSync) begin
      successor <= NO_NUMBER;
    end else if (opStart) begin
      if (!linkEnabled || successorIsStop) begin
        successor <= NO_NUMBER;  // [R7]
      end else begin
        successor <= successorNumber;  // [R7]
      end
    end
  end

  // loop origin and iteration count
  // a pass on the entry edge already counts as the first iteration
  always_ff @(posedge clk_sys or negedge rstSync) begin
    if (!rstSync) begin
      loopStart <= NO_NUMBER;
      loopCount <= 32'h0;
      loopWas   <= 1'b0;
    end else begin
      loopWas <= loopActive;
      if (!loopActive) begin
        loopStart <= NO_NUMBER;  // [R8]
        loopCount <= 32'h0;  // [R9]
      end else if (!loopWas) begin
        loopStart <= loopOrigin;  // [R8]
        if (loopPass) begin
          loopCount <= 32'h1;  // [R9]
        end else begin
          loopCount <= 32'h0;  // [R9]
        end
      end else if (loopPass) begin
        loopCount <= loopCount + 32'h1;  // [R9]
      end
    end
  end

  // load magnitude so both directions add to the total; sum wraps on overflow
  // the most negative sample has no positive twin and is added as is
  always_comb begin
    if (loadSample[31]) begin
      loadMag = 32'h0 - loadSample;  // [R16]
    end else begin
      loadMag = loadSample;  // [R16]
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync) begin
    if (!rstSync) begin
      loadSum <= 32'h0;
    end else if (loadValid && running) begin
      loadSum <= loadSum + loadMag;  // [R16]
    end
  end

  // revolution prescaler shared by both meters
  assign unitTick = revPulse && (revSub == 16'(REV_UNIT - 1));

  always_ff @(posedge clk_sys or negedge rstSync) begin
    if (!rstSync) begin
      revSub <= 16'h0;
    end else if (revPulse) begin
      if (unitTick) begin
        revSub <= 16'h0;
      end else begin
        revSub <= revSub + 16'h1;
      end
    end
  end

  // lifetime meter has no clear path at all
  always_ff @(posedge clk_sys or negedge rstSync) begin
    if (!rstSync) begin
      lifetimeRevs <= 32'h0;
    end else if (unitTick) begin
      lifetimeRevs <= lifetimeRevs + 32'h1;  // [R14]
    end
  end

  // a unit arriving with the clear is kept so no travel is lost
  always_ff @(posedge clk_sys or negedge rstSync) begin
    if (!rstSync) begin
      tripRevs <= 32'h0;
    end else if (tripClear) begin
      if (unitTick) begin
        tripRevs <= 32'h1;  // [R15]
      end else begin
        tripRevs <= 32'h0;  // [R15]
      end
    end else if (unitTick) begin
      tripRevs <= tripRevs + 32'h1;  // [R15]
    end
  end

  // event latches: capture wins over a clear in the same cycle
  generate
    for (genvar e = 0; e < EV_COUNT; e++) begin : g_event
      always_ff @(posedge clk_sys or negedge rstSync) begin
        if (!rstSync) begin
          evCmd[e] <= 32'h0;
          evFb[e]  <= 32'h0;
        end else if (eventPulse[e]) begin
          evCmd[e] <= cmdPosition;  // [R1] [R2] [R3] [R4] [R5]
          evFb[e]  <= fbPosition;  // [R1] [R2] [R3] [R4] [R5]
        end else if (eventClear[e]) begin
          evCmd[e] <= 32'h0;  // [R6]
          evFb[e]  <= 32'h0;  // [R6]
        end
      end
    end
  endgenerate

  // history shifts on each start; entry 0 is the running operation
  // entries beyond the depth are dropped, oldest first
  always_ff @(posedge clk_sys or negedge rstSync) begin
    if (!rstSync) begin
      for (int i = 0; i < HIST_DEPTH; i++) begin
        hist[i] <= NO_NUMBER;
      end
    end else if (opStart) begin
      hist[0] <= opNumber;  // [R10]
      for (int i = 1; i < HIST_DEPTH; i++) begin
        hist[i] <= hist[i-1];
      end
    end
  end

  // sign extension keeps sub-zero readings negative on the 32-bit bus
  assign driverTempWide = {{16{driverTemp[15]}}, driverTemp};  // [R13]
  assign motorTempWide  = {{16{motorTemp[15]}}, motorTemp};  // [R13]

  function automatic logic [31:0] lookup(input logic [15:0] a);
    logic [15:0] base;
    logic [15:0] idx;
    base   = {a[15:1], 1'b0};
    idx    = (base - HR_EXEC_HISTORY_NEWEST) >> 1;
    lookup = 32'h0;
    case (base)
      HR_IO_SNAPSHOT:           lookup = ioSync;  // [R18]
      HR_TORQUE_RATIO:          lookup = torqueRatio;  // [R17]
      HR_CUMULATIVE_LOAD:       lookup = loadSum;
      HR_TARGET_POSITION:       lookup = target;
      HR_SUCCESSOR_DATA_NUMBER: lookup = successor;
      HR_LOOP_START_NUMBER:     lookup = loopStart;
      HR_LOOP_ITERATIONS:       lookup = loopCount;
      HR_STEP_EVENT_CMD_POS:    lookup = evCmd[EV_STEP];
      HR_STEP_EVENT_FB_POS:     lookup = evFb[EV_STEP];
      HR_LOW_EVENT_CMD_POS:     lookup = evCmd[EV_LOW];
      HR_LOW_EVENT_FB_POS:      lookup = evFb[EV_LOW];
      HR_HIGH_EVENT_CMD_POS:    lookup = evCmd[EV_HIGH];
      HR_HIGH_EVENT_FB_POS:     lookup = evFb[EV_HIGH];
      HR_HALT_EVENT_CMD_POS:    lookup = evCmd[EV_HALT];
      HR_HALT_EVENT_FB_POS:     lookup = evFb[EV_HALT];
      HR_INFO_CODE:             lookup = infoCode;  // [R19]
      HR_DRIVER_TEMP:           lookup = driverTempWide;  // [R13]
      HR_MOTOR_TEMP:            lookup = motorTempWide;  // [R13]
      HR_LIFETIME_REVS:         lookup = lifetimeRevs;  // [R14]
      HR_RESETTABLE_REVS:       lookup = tripRevs;  // [R15]
      default: begin
        if (base >= HR_EXEC_HISTORY_NEWEST && idx < 16'(HIST_DEPTH)) begin
          if (running) begin
            lookup = hist[idx[$clog2(HIST_DEPTH)-1:0]];  // [R10]
          end else begin
            lookup = NO_NUMBER;  // [R10]
          end
        end
      end
    endcase
  endfunction : lookup

  // last code in use: the final history entry
  localparam logic [15:0] NC_CODE_LAST =
    CMD_CODE_BASE + 16'((HR_EXEC_HISTORY_NEWEST - HR_IO_SNAPSHOT) >> 1) + 16'(HIST_DEPTH - 1);

  assign hrWord = lookup(hrAddr);

  // command code maps onto the same items, one code per register pair;
  // codes past the table would wrap the address arithmetic onto a real item
  always_comb begin
    ncAddr = HR_IO_SNAPSHOT + 16'((ncCode - CMD_CODE_BASE) << 1);
    ncWord = 32'h0;
    if (ncCode >= CMD_CODE_BASE && ncCode <= NC_CODE_LAST) begin
      ncWord = lookup(ncAddr);
    end
  end

  // upper half read freezes the lower half so the pair is one coherent value
  always_ff @(posedge clk_sys or negedge rstSync) begin
    if (!rstSync) begin
      pairLow  <= 16'h0;
      pairAddr <= 16'h0;
      pairHeld <= 1'b0;
    end else if (hrRead) begin
      pairHeld <= !hrAddr[0];  // [R20]
      pairAddr <= hrAddr + 16'h1;
      pairLow  <= hrWord[15:0];
    end
  end

  // any read other than the matching lower half drops the frozen half
  always_ff @(posedge clk_sys or negedge rstSync) begin
    if (!rstSync) begin
      hrValid <= 1'b0;
    end else begin
      hrValid <= hrRead;  // [R20]
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync) begin
    if (!rstSync) begin
      hrData  <= 16'h0;
    end else begin
      if (hrRead) begin
        if (!hrAddr[0]) begin
          hrData <= hrWord[31:16];  // [R20]
        end else if (pairHeld && pairAddr == hrAddr) begin
          hrData <= pairLow;  // [R20]
        end else begin
          hrData <= hrWord[15:0];
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync) begin
    if (!rstSync) begin
      ncValid <= 1'b0;
    end else begin
      ncValid <= ncRead;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync) begin
    if (!rstSync) begin
      ncData  <= 32'h0;
    end else begin
      if (ncRead) begin
        ncData <= ncWord;
      end
    end
  end

endmodule : mmrb_monitor_bank
`default_nettype wire

// file: mmrb_bank_monitor.sv
// assertion checker for the motion monitor register bank
`timescale 1ns/1ps
`default_nettype none
module mmrb_bank_monitor (
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic [31:0] cmdPosition,
  input wire logic        running,
  input wire logic [3:0]  eventPulse,
  input wire logic [3:0]  eventClear,
  input wire logic [15:0] driverTemp,
  input wire logic        hrRead,
  input wire logic        hrValid,
  input wire logic        ncRead,
  input wire logic [15:0] ncCode,
  input wire logic [31:0] ncData,
  input wire logic        ncValid
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  AST_HR_ANSWER: assert property (hrRead |=> hrValid)
    else $error("holding read not answered");
  AST_NC_ANSWER: assert property (ncRead |=> ncValid)
    else $error("code read not answered");
  AST_NC_QUIET: assert property (!ncRead |=> !ncValid)
    else $error("code answer without request");
  AST_STEP_CAP: assert property (eventPulse[0] ##1 (ncRead && ncCode == 16'h2073)
    |=> ncData == $past(cmdPosition, 2)) else $error("step event position wrong");
  AST_LOW_CAP: assert property (eventPulse[1] ##1 (ncRead && ncCode == 16'h2075)
    |=> ncData == $past(cmdPosition, 2)) else $error("low event position wrong");
  AST_HIGH_CAP: assert property (eventPulse[2] ##1 (ncRead && ncCode == 16'h2077)
    |=> ncData == $past(cmdPosition, 2)) else $error("high event position wrong");
  AST_HALT_CAP: assert property (eventPulse[3] ##1 (ncRead && ncCode == 16'h2079)
    |=> ncData == $past(cmdPosition, 2)) else $error("halt event position wrong");
  AST_CLEARED: assert property ((eventClear[0] && !eventPulse[0]) ##1
    (ncRead && ncCode == 16'h2073) |=> ncData == 32'h0) else $error("cleared latch not 0");
  AST_HIST_STOP: assert property (!running && ncRead && ncCode == 16'h2081
    |=> ncData == 32'hffffffff) else $error("history not -1 when stopped");
  AST_TEMP: assert property (ncRead && ncCode == 16'h207c
    |=> ncData == 32'($signed($past(driverTemp)))) else $error("driver temp wrong");
endmodule : mmrb_bank_monitor
bind mmrb_monitor_bank mmrb_bank_monitor mmrb_bank_monitor_i (.*);
`default_nettype wire

// file: mmrb_host_model.sv
// host model reading 32-bit items as holding-register pairs
`timescale 1ns/1ps
`default_nettype none
module mmrb_host_model (
  input  wire logic        clk_sys,
  output var  logic        hrRead,
  output var  logic [15:0] hrAddr,
  input  wire logic [15:0] hrData
);
  initial begin
    hrRead = 1'b0;
    hrAddr = 16'h0;
  end
  // upper half first, so the device freezes the matching lower half
  task automatic read32(input logic [15:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    hrRead <= 1'b1;
    hrAddr <= a;
    @(posedge clk_sys);
    hrAddr <= a + 16'h1;
    #1;
    v[31:16] = hrData;
    @(posedge clk_sys);
    hrRead <= 1'b0;
    hrAddr <= ~a;
    #1;
    v[15:0] = hrData;
  endtask : read32
endmodule : mmrb_host_model
`default_nettype wire

// file: motion_monitor_register_bank_tb_top.sv
// self-checking testbench of the motion monitor register bank
`timescale 1ns/1ps
`default_nettype none
module motion_monitor_register_bank_tb_top;
  import mmrb_pkg::*;
  localparam int RU = 2;
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic [31:0] ioPins, cmdPosition, fbPosition, torqueRatio, loadSample, opNumber;
  logic [31:0] opDestination, successorNumber, loopOrigin, infoCode, v;
  logic [15:0] driverTemp, motorTemp, ncCode;
  logic [3:0]  eventPulse, eventClear;
  logic        loadValid, running, opStart, opUsesDestination, linkEnabled, successorIsStop;
  logic        loopActive, loopPass, revPulse, tripClear, ncRead;
  wire  logic [15:0] hrData, hrAddr;
  wire  logic [31:0] ncData;
  wire  logic        hrRead, hrValid, ncValid;
  int          fails = 0;
  int          nCompared = 0;
  mmrb_monitor_bank #(.HIST_DEPTH(HISTORY_DEPTH), .REV_UNIT(RU)) mmrb_monitor_bank_i (.*);
  mmrb_host_model host_i (.*);
  always #10 clk_sys = ~clk_sys;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    nCompared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // a read also ends every one-cycle pulse raised at the edge before
  task automatic ncChk(input string what, input logic [15:0] c, input logic [31:0] exp);
    @(posedge clk_sys);
    {opStart, loopPass, revPulse, tripClear, loadValid, eventPulse, eventClear} <= '0;
    ncRead <= 1'b1;
    ncCode <= c;
    @(posedge clk_sys);
    ncRead <= 1'b0;
    #1;
    chk("ncValid", 32'h1, {31'h0, ncValid});
    chk(what, exp, ncData);
  endtask : ncChk
  task automatic hrChk(input string what, input logic [15:0] a, input logic [31:0] exp);
    host_i.read32(a, v);
    chk("hrValid", 32'h1, {31'h0, hrValid});
    chk(what, exp, v);
  endtask : hrChk
  task automatic evCap(input int k, input logic [31:0] c, input logic [31:0] f);
    @(posedge clk_sys);
    cmdPosition <= c;
    fbPosition <= f;
    eventPulse[k] <= 1'b1;
    ncChk("event cmd", 16'h2073 + 16'(2 * k), c);
    hrChk("event fb", HR_STEP_EVENT_FB_POS + 16'(4 * k), f);
  endtask : evCap
  task automatic tEvents();
    for (int k = 0; k < 4; k++) begin
      evCap(k, 32'h1000 + k, 32'hffff0000 - k);
    end
    evCap(0, 32'h00abcdef, 32'h7);
    @(posedge clk_sys);
    eventClear[0] <= 1'b1;
    ncChk("cleared cmd", 16'h2073, 32'h0);
    hrChk("cleared fb", HR_STEP_EVENT_FB_POS, 32'h0);
  endtask : tEvents
  task automatic tOps();
    @(posedge clk_sys);
    {running, opStart, opUsesDestination, linkEnabled} <= 4'hf;
    {opNumber, opDestination, successorNumber, cmdPosition} <= {32'h3, 32'h1234, 32'h5, 32'h77};
    ncChk("target", 16'h206f, 32'h1234);
    ncChk("history new", 16'h2080, 32'h3);
    @(posedge clk_sys);
    running <= 1'b0;
    ncChk("successor kept", 16'h2070, 32'h5);
    ncChk("history stop", 16'h2081, NO_NUMBER);
    @(posedge clk_sys);
    {running, opStart, opUsesDestination, successorIsStop} <= 4'hd;
    opNumber <= 32'h4;
    ncChk("target start", 16'h206f, 32'h77);
    ncChk("successor stop", 16'h2070, NO_NUMBER);
    ncChk("history old", 16'h2081, 32'h3);
  endtask : tOps
  task automatic tLoop();
    @(posedge clk_sys);
    loopActive <= 1'b1;
    loopOrigin <= 32'h7;
    ncChk("loop origin", 16'h2071, 32'h7);
    for (int i = 1; i < 3; i++) begin
      @(posedge clk_sys);
      loopPass <= 1'b1;
      ncChk("loop count", 16'h2072, 32'(i));
    end
    @(posedge clk_sys);
    loopActive <= 1'b0;
    ncChk("loop origin off", 16'h2071, NO_NUMBER);
    ncChk("loop count off", 16'h2072, 32'h0);
  endtask : tLoop
  task automatic tMeters();
    repeat (3 * RU) begin
      @(posedge clk_sys);
      revPulse <= 1'b1;
      @(posedge clk_sys);
      revPulse <= 1'b0;
    end
    hrChk("odometer", HR_LIFETIME_REVS, 32'h3);
    @(posedge clk_sys);
    tripClear <= 1'b1;
    ncChk("trip cleared", 16'h207f, 32'h0);
    ncChk("odometer kept", 16'h207e, 32'h3);
    @(posedge clk_sys);
    {running, loadValid, loadSample} <= {2'b11, 32'hfffffffb};
    @(posedge clk_sys);
    loadSample <= 32'h3;
    ncChk("load", 16'h206d, 32'h8);
  endtask : tMeters
  task automatic tLive();
    @(posedge clk_sys);
    {ioPins, torqueRatio, infoCode} <= {32'ha5c30f01, 32'h64, 32'h2a};
    {driverTemp, motorTemp} <= {16'hff38, 16'h0123};
    repeat (3) @(posedge clk_sys);
    hrChk("io", HR_IO_SNAPSHOT, 32'ha5c30f01);
    ncChk("torque", 16'h206b, 32'h64);
    ncChk("info", 16'h207b, 32'h2a);
    ncChk("driver temp", 16'h207c, 32'hffffff38);
    ncChk("motor temp", 16'h207d, 32'h123);
    hrChk("unmapped", 16'h00d8, 32'h0);
    ncChk("far code", 16'ha06a, 32'h0);
  endtask : tLive
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict
  initial begin
    {ioPins, cmdPosition, fbPosition, torqueRatio, loadSample, opNumber, opDestination} = '0;
    {successorNumber, loopOrigin, infoCode, driverTemp, motorTemp, ncCode} = '0;
    {eventPulse, eventClear, loadValid, running, opStart, opUsesDestination} = '0;
    {linkEnabled, successorIsStop, loopActive, loopPass, revPulse, tripClear, ncRead} = '0;
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk_sys);
    tEvents();
    tOps();
    tLoop();
    tMeters();
    tLive();
    print_verdict();
  end
  // the sequence needs well under a thousand cycles
  initial begin
    #200000;
    fails++;
    print_verdict();
  end
endmodule : motion_monitor_register_bank_tb_top
`default_nettype wire
